// ### rtl/usb_pwr_pkg.sv
// Constants for the USB bridge power and control register block.
// Assumes an APB master on a 12-bit byte address, 32-bit data.
package usb_pwr_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_POWER_CONTROL = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;

  // ----------------------------------------
  // Power control fields
  // ----------------------------------------
  localparam int BIT_SUSPEND_X = 4;
  localparam int BIT_PHY_SUSPEND = 3;
  localparam int BIT_BUS_POWER = 2;
  localparam int BIT_SOFT_RST_N = 1;
  localparam int BIT_USB_RESET = 0;

  // ----------------------------------------
  // Interrupt event fields (status and mask)
  // ----------------------------------------
  localparam int EV_W = 5;
  localparam int EV_SUSPEND = 0;
  localparam int EV_RESUME = 1;
  localparam int EV_POWER_CHG = 2;
  localparam int EV_BUS_RESET = 3;
  localparam int EV_BLOCKED = 4;

  // ----------------------------------------
  // Synchroniser lanes: suspend_x, bus power, bus reset
  // ----------------------------------------
  localparam int SYNC_W = 3;
  localparam int LANE_SUSP = 0;
  localparam int LANE_PWR = 1;
  localparam int LANE_RST = 2;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [2:0] RST_SYNC = 3'h1;
  localparam logic RST_PHY_SUSPEND = 1'b0;
  localparam logic RST_SOFT_RST_N = 1'b1;
  localparam logic [4:0] RST_EVENTS = 5'h00;

endpackage

// ### rtl/usb_pwr_sync.sv
// Two-flop synchronisers, one lane per bit, into the system clock.
// Assumes inputs are asynchronous levels; outputs are second-stage flops.
`timescale 1ns/1ps
module usb_pwr_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous levels in
  input wire logic [usb_pwr_pkg::SYNC_W-1:0] i_async,
  // Synchronised levels out
  output logic [usb_pwr_pkg::SYNC_W-1:0] o_sync
);
  import usb_pwr_pkg::*;

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [SYNC_W-1:0] nxt_meta;
  logic [SYNC_W-1:0] nxt_sync;

  // ----------------------------------------
  // Per-lane stages
  // ----------------------------------------
  for (genvar g = 0; g < SYNC_W; g++) begin : g_lane
    // First stage only feeds the second stage
    always_comb begin
      nxt_meta[g] = i_rst_n ? i_async[g] : RST_SYNC[g];
      nxt_sync[g] = i_rst_n ? meta_ff[g] : RST_SYNC[g];
    end
  end

  // Register both stages
  always_ff @(posedge i_clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign o_sync = sync_ff;

endmodule // usb_pwr_sync

// ### rtl/usb_pwr_ctrl.sv
// USB bridge power and control register, APB slave, with interrupts.
// Assumes APB master on i_clk, core and PHY status pins asynchronous,
// and core/DMA access requests generated on i_clk.
`timescale 1ns/1ps
module usb_pwr_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [usb_pwr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [usb_pwr_pkg::DATA_W-1:0] i_pwdata,
  output logic [usb_pwr_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core and bus status pins (asynchronous)
  input wire logic i_suspend_x,
  input wire logic i_bus_power_in,
  input wire logic i_usb_reset,
  // Access requests from bridge logic (same clock)
  input wire logic i_core_acc_req,
  input wire logic i_dma_read_request_reg_req,
  // Access grants
  output logic o_core_acc_grant,
  output logic o_dma_read_request_reg_grant,
  // PHY and bridge pins
  output logic o_transceiver_sleep_out_n,
  output logic o_bridge_rst_out_n,
  // Interrupt
  output logic o_irq
);
  import usb_pwr_pkg::*;

  // ----------------------------------------
  // Synchronised status
  // ----------------------------------------
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_lvl;
  logic susp_s;
  logic pwr_s;
  logic rst_s;

  assign async_in[LANE_SUSP] = i_suspend_x;
  assign async_in[LANE_PWR] = i_bus_power_in;
  assign async_in[LANE_RST] = i_usb_reset;

  usb_pwr_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(async_in),
    .o_sync(sync_lvl)
  );

  assign susp_s = sync_lvl[LANE_SUSP];
  assign pwr_s = sync_lvl[LANE_PWR];
  assign rst_s = sync_lvl[LANE_RST];

  // ----------------------------------------
  // Edge detection on synchronised levels
  // ----------------------------------------
  logic susp_d_ff;
  logic pwr_d_ff;
  logic rst_d_ff;
  logic nxt_susp_d;
  logic nxt_pwr_d;
  logic nxt_rst_d;
  logic ev_suspend;
  logic ev_resume;
  logic ev_power;
  logic ev_busrst;

  // Delayed copies reset to the synchroniser reset values, no false edge
  always_comb begin
    nxt_susp_d = i_rst_n ? susp_s : RST_SYNC[LANE_SUSP];
    nxt_pwr_d = i_rst_n ? pwr_s : RST_SYNC[LANE_PWR];
    nxt_rst_d = i_rst_n ? rst_s : RST_SYNC[LANE_RST];
  end

  always_ff @(posedge i_clk) begin
    susp_d_ff <= nxt_susp_d;
    pwr_d_ff <= nxt_pwr_d;
    rst_d_ff <= nxt_rst_d;
  end

  // Suspend_x is active low: a rise means the bus resumed
  assign ev_suspend = susp_d_ff & ~susp_s;
  assign ev_resume = ~susp_d_ff & susp_s;
  assign ev_power = pwr_d_ff ^ pwr_s;
  assign ev_busrst = ~rst_d_ff & rst_s;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic nxt_pready;
  logic nxt_pslverr;
  logic [DATA_W-1:0] nxt_prdata;
  logic apb_acc;
  logic apb_done;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic hit;

  // One wait state: pready rises one cycle into the access phase
  assign apb_acc = i_psel & i_penable & ~pready_ff;
  assign apb_done = i_psel & i_penable & pready_ff;
  assign wr_ctrl = apb_done & i_pwrite & (i_paddr == OFS_POWER_CONTROL);
  assign wr_stat = apb_done & i_pwrite & (i_paddr == OFS_IRQ_STATUS);
  assign wr_mask = apb_done & i_pwrite & (i_paddr == OFS_IRQ_MASK);
  assign hit = (i_paddr == OFS_POWER_CONTROL) | (i_paddr == OFS_IRQ_STATUS) |
               (i_paddr == OFS_IRQ_MASK);

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic phy_susp_ff;
  logic soft_rst_n_ff;
  logic sleep_n_ff;
  logic brst_n_ff;
  logic nxt_phy_susp;
  logic nxt_soft_rst_n;
  logic nxt_sleep_n;
  logic nxt_brst_n;

  always_comb begin
    nxt_phy_susp = phy_susp_ff;
    nxt_soft_rst_n = soft_rst_n_ff;
    if (wr_ctrl) begin
      nxt_phy_susp = i_pwdata[BIT_PHY_SUSPEND];
      nxt_soft_rst_n = i_pwdata[BIT_SOFT_RST_N];
    end
    // resume clears suspend
    // Resume beats a same-cycle write: a stale write must not re-sleep the PHY
    if (ev_resume) begin
      nxt_phy_susp = 1'b0;
    end
    if (!i_rst_n) begin
      nxt_phy_susp = RST_PHY_SUSPEND;
      nxt_soft_rst_n = RST_SOFT_RST_N;
    end
    // Pins take the next bit values, so pin and bit switch together
    nxt_sleep_n = ~nxt_phy_susp;
    nxt_brst_n = nxt_soft_rst_n;
  end

  // sleep pin low while suspend bit set
  // reset pin follows only the bit
  always_ff @(posedge i_clk) begin
    phy_susp_ff <= nxt_phy_susp;
    soft_rst_n_ff <= nxt_soft_rst_n;
    sleep_n_ff <= nxt_sleep_n;
    brst_n_ff <= nxt_brst_n;
  end

  assign o_transceiver_sleep_out_n = sleep_n_ff;
  assign o_bridge_rst_out_n = brst_n_ff;

  // ----------------------------------------
  // Access gating
  // ----------------------------------------
  logic core_gnt_ff;
  logic dma_gnt_ff;
  logic nxt_core_gnt;
  logic nxt_dma_gnt;
  logic ev_blocked;

  always_comb begin
    nxt_core_gnt = i_rst_n & i_core_acc_req & ~phy_susp_ff;
    nxt_dma_gnt = i_rst_n & i_dma_read_request_reg_req & ~phy_susp_ff;
  end

  assign ev_blocked = phy_susp_ff & (i_core_acc_req | i_dma_read_request_reg_req);

  always_ff @(posedge i_clk) begin
    core_gnt_ff <= nxt_core_gnt;
    dma_gnt_ff <= nxt_dma_gnt;
  end

  assign o_core_acc_grant = core_gnt_ff;
  assign o_dma_read_request_reg_grant = dma_gnt_ff;

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic [EV_W-1:0] stat_ff;
  logic [EV_W-1:0] mask_ff;
  logic irq_ff;
  logic [EV_W-1:0] nxt_stat;
  logic [EV_W-1:0] nxt_mask;
  logic [EV_W-1:0] ev_vec;
  logic nxt_irq;

  assign ev_vec = {ev_blocked, ev_busrst, ev_power, ev_resume, ev_suspend};

  // Write-one-to-clear; a new event in the clear cycle survives
  always_comb begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~i_pwdata[EV_W-1:0];
    end
    nxt_stat = nxt_stat | ev_vec;
    if (wr_mask) begin
      nxt_mask = i_pwdata[EV_W-1:0];
    end
    if (!i_rst_n) begin
      nxt_stat = RST_EVENTS;
      nxt_mask = RST_EVENTS;
    end
    // Level from the values being stored, so no extra cycle of lag
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge i_clk) begin
    stat_ff <= nxt_stat;
    mask_ff <= nxt_mask;
    irq_ff <= nxt_irq;
  end

  assign o_irq = irq_ff;

  // ----------------------------------------
  // Read data and response
  // ----------------------------------------
  // Read data is captured on the same edge that raises pready, held for the master
  always_comb begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    if (apb_acc) begin
      nxt_pready = 1'b1;
      nxt_pslverr = ~hit;
      nxt_prdata = '0;
      if (!i_pwrite) begin
        unique case (i_paddr)
          OFS_POWER_CONTROL: begin
            nxt_prdata[BIT_SUSPEND_X] = susp_s;
            nxt_prdata[BIT_PHY_SUSPEND] = phy_susp_ff;
            nxt_prdata[BIT_BUS_POWER] = pwr_s;
            nxt_prdata[BIT_SOFT_RST_N] = soft_rst_n_ff;
            nxt_prdata[BIT_USB_RESET] = rst_s;
          end
          OFS_IRQ_STATUS: begin
            nxt_prdata[EV_W-1:0] = stat_ff;
          end
          OFS_IRQ_MASK: begin
            nxt_prdata[EV_W-1:0] = mask_ff;
          end
          default: begin
            nxt_prdata = '0;
          end
        endcase
      end
    end
    if (!i_rst_n) begin
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    pready_ff <= nxt_pready;
    pslverr_ff <= nxt_pslverr;
    prdata_ff <= nxt_prdata;
  end

  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic rd_ctrl;
  assign rd_ctrl = apb_acc & ~i_pwrite & (i_paddr == OFS_POWER_CONTROL);

  susp_read_a: assert property (
    rd_ctrl |=> o_pready && (o_prdata[BIT_SUSPEND_X] == $past(susp_s)))
    else $error("suspend status read mismatch");

  sleep_pin_a: assert property (
    wr_ctrl && i_pwdata[BIT_PHY_SUSPEND] && !ev_resume |=> !o_transceiver_sleep_out_n)
    else $error("sleep pin not driven low after write");

  access_block_a: assert property (
    phy_susp_ff && (i_core_acc_req || i_dma_read_request_reg_req)
    |=> !o_core_acc_grant && !o_dma_read_request_reg_grant && stat_ff[EV_BLOCKED])
    else $error("access granted while suspended");

  resume_clear_a: assert property (
    ev_resume |=> !phy_susp_ff && o_transceiver_sleep_out_n)
    else $error("suspend bit not cleared on resume");

  power_read_a: assert property (
    rd_ctrl |=> o_prdata[BIT_BUS_POWER] == $past(pwr_s))
    else $error("bus power read mismatch");

  soft_reset_a: assert property (
    wr_ctrl && !i_pwdata[BIT_SOFT_RST_N] |=> !o_bridge_rst_out_n ##1 !o_bridge_rst_out_n)
    else $error("bridge reset pin not asserted");

  reset_hold_a: assert property (
    !o_bridge_rst_out_n && !wr_ctrl |=> !o_bridge_rst_out_n)
    else $error("bridge reset released without write");

  busrst_read_a: assert property (
    rd_ctrl |=> o_prdata[BIT_USB_RESET] == $past(rst_s))
    else $error("bus reset read mismatch");

  sync_delay_a: assert property (
    $past(i_rst_n, 3) |-> rst_s == $past(i_usb_reset, 2))
    else $error("bus reset not two flops behind pin");

  susp_sync_a: assert property (
    $past(i_rst_n, 3) |-> susp_s == $past(i_suspend_x, 2))
    else $error("suspend status not two flops behind pin");

  power_sync_a: assert property (
    $past(i_rst_n, 3) |-> pwr_s == $past(i_bus_power_in, 2))
    else $error("bus power not two flops behind pin");

  grant_pass_a: assert property (
    !phy_susp_ff |=> o_core_acc_grant == $past(i_core_acc_req) &&
    o_dma_read_request_reg_grant == $past(i_dma_read_request_reg_req))
    else $error("access grant wrong while awake");

  reset_release_a: assert property (
    wr_ctrl && i_pwdata[BIT_SOFT_RST_N] |=> o_bridge_rst_out_n)
    else $error("bridge reset pin not released");

  irq_level_a: assert property (
    o_irq == |(stat_ff & mask_ff))
    else $error("interrupt level mismatch");

endmodule // usb_pwr_ctrl

// ### tb/usb_core_model.sv
// Model of the USB core and bus pins facing the power control block.
// Assumes the bench requests levels; the model moves the pins on i_clk.
`timescale 1ns/1ps
module usb_core_model (
  // Clock
  input wire logic i_clk,
  // Requested levels
  input wire logic i_want_awake,
  input wire logic i_want_power,
  input wire logic i_want_reset,
  input wire logic i_want_access,
  // Core pins
  output logic o_suspend_x,
  output logic o_bus_power_in,
  output logic o_usb_reset,
  output logic o_core_acc_req
);
  // -------------------------
  // Pin drivers
  // -------------------------
  // Pins move just after an edge, like real core flops
  always @(posedge i_clk) begin
    o_suspend_x <= i_want_awake;
    o_bus_power_in <= i_want_power;
    o_usb_reset <= i_want_reset;
    o_core_acc_req <= i_want_access;
  end
endmodule // usb_core_model

// ### tb/tb.sv
// Self-checking bench for the power control register block.
// Assumes one 200 MHz clock; the APB master waits at most 50 cycles for pready.
`timescale 1ns/1ps
module tb;
  import usb_pwr_pkg::*;
  typedef struct {logic [2:0] pins; logic [31:0] exp;} row_t;
  logic i_clk = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, susp_x, pwr, ures, creq, dreq = 0, cgnt, dgnt, sleep_n, brst_n, irq;
  logic awake = 1, power = 0, breset = 0, access = 0;
  int n_errors = 0, check_count = 0;
  row_t rows [5] = '{'{3'b100, 32'h12}, '{3'b010, 32'h06}, '{3'b001, 32'h03},
                     '{3'b111, 32'h17}, '{3'b000, 32'h02}};
  // -------------------------
  // Clock, design and far side
  // -------------------------
  always #2.5 i_clk = ~i_clk;
  usb_pwr_ctrl i_usb_pwr_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_suspend_x(susp_x), .i_bus_power_in(pwr), .i_usb_reset(ures),
    .i_core_acc_req(creq), .i_dma_read_request_reg_req(dreq), .o_core_acc_grant(cgnt),
    .o_dma_read_request_reg_grant(dgnt), .o_transceiver_sleep_out_n(sleep_n),
    .o_bridge_rst_out_n(brst_n), .o_irq(irq));
  usb_core_model i_usb_core_model (.i_clk(i_clk), .i_want_awake(awake), .i_want_power(power),
    .i_want_reset(breset), .i_want_access(access), .o_suspend_x(susp_x), .o_bus_power_in(pwr),
    .o_usb_reset(ures), .o_core_acc_req(creq));
  // -------------------------
  // Tasks
  // -------------------------
  // Request held until pready is seen high at a rising edge, or 50 edges pass; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // -------------------------
  // Watchdog
  // -------------------------
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
  // -------------------------
  // Main sequence
  // -------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1;
    waitn(4);
    chk("sleep_n", 1, sleep_n);
    chk("brst_n", 1, brst_n);
    // Pin levels against status bits
    foreach (rows[k]) begin
      @(posedge i_clk);
      {awake, power, breset} <= rows[k].pins;
      waitn(5);
      apb(0, OFS_POWER_CONTROL, 0);
      chk("ctrl", rows[k].exp, rd);
    end
    // Suspend, then blocked accesses
    awake <= 0; power <= 1;
    waitn(5);
    apb(1, OFS_POWER_CONTROL, 32'h0a);
    apb(0, OFS_POWER_CONTROL, 0);
    chk("ctrl", 32'h0e, rd);
    chk("sleep_n", 0, sleep_n);
    apb(1, OFS_IRQ_STATUS, 32'h1f);
    @(posedge i_clk);
    access <= 1; dreq <= 1;
    waitn(3);
    chk("cgnt", 0, cgnt);
    chk("dgnt", 0, dgnt);
    @(posedge i_clk);
    access <= 0; dreq <= 0;
    apb(0, OFS_IRQ_STATUS, 0);
    chk("status", 32'h10, rd);
    chk("irq", 0, irq);
    apb(1, OFS_IRQ_MASK, 32'h10);
    waitn(2);
    chk("irq", 1, irq);
    apb(1, OFS_IRQ_STATUS, 32'h10);
    waitn(2);
    chk("irq", 0, irq);
    // Resume clears the sleep bit
    @(posedge i_clk);
    awake <= 1;
    waitn(8);
    apb(0, OFS_POWER_CONTROL, 0);
    chk("ctrl", 32'h16, rd);
    chk("sleep_n", 1, sleep_n);
    @(posedge i_clk);
    access <= 1; dreq <= 1;
    waitn(3);
    chk("cgnt", 1, cgnt);
    chk("dgnt", 1, dgnt);
    // Soft reset only with DMA requests idle
    @(posedge i_clk);
    access <= 0; dreq <= 0;
    apb(1, OFS_POWER_CONTROL, 32'h00);
    waitn(20);
    chk("brst_n", 0, brst_n);
    apb(0, OFS_POWER_CONTROL, 0);
    chk("ctrl", 32'h14, rd);
    apb(1, OFS_POWER_CONTROL, 32'h02);
    waitn(2);
    chk("brst_n", 1, brst_n);
    // Unmapped word answers with an error
    apb(0, 12'h00c, 0);
    chk("err", 1, er);
    chk("rdata", 0, rd);
    // Mid-run reset returns pins, bits and mask to idle values
    apb(1, OFS_POWER_CONTROL, 32'h08);
    waitn(2);
    chk("sleep_n", 0, sleep_n);
    chk("brst_n", 0, brst_n);
    @(posedge i_clk);
    i_rst_n <= 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1;
    waitn(2);
    chk("sleep_n", 1, sleep_n);
    chk("brst_n", 1, brst_n);
    chk("irq", 0, irq);
    apb(0, OFS_POWER_CONTROL, 0);
    chk("ctrl", 32'h16, rd);
    apb(0, OFS_IRQ_MASK, 0);
    chk("mask", 0, rd);
    complete_run();
  end
endmodule // tb
